// File: pkg/bmw_map.vh
// Register map, field positions, reset values and bus codes of the memory window bank
`ifndef BMW_MAP_VH
`define BMW_MAP_VH

// Bus geometry
`define BMW_ADDR_W        12
`define BMW_DATA_W        32
`define BMW_STRB_W        4

// Register byte offsets
`define BMW_OFS_MEM       12'h020
`define BMW_OFS_PREF      12'h024
`define BMW_OFS_PFLOOR_HI 12'h028
`define BMW_OFS_PCEIL_HI  12'h02c
`define BMW_OFS_STATUS    12'h100

// Field positions inside the two packed window registers
`define BMW_FLOOR_LSB     4
`define BMW_FLOOR_MSB     15
`define BMW_CEIL_LSB      20
`define BMW_CEIL_MSB      31

// Constant nibbles below each window field
`define BMW_RESV_NIBBLE   4'h0
`define BMW_ADDR64_IND    4'h1

// Reset values and the forward counter saturation limit
`define BMW_WIN_RST       12'h000
`define BMW_HI_RST        32'h00000000
`define BMW_CNT_RST       16'h0000
`define BMW_CNT_MAX       16'hffff

// Implied low address bits of each bound
`define BMW_LOW_FILL      20'h00000
`define BMW_HIGH_FILL     20'hfffff

// Status register layout
`define BMW_ST_MEM_BIT    0
`define BMW_ST_PREF_BIT   1
`define BMW_ST_FWD_BIT    2
`define BMW_ST_CNT_LSB    16

// Response codes
`define BMW_RESP_OKAY     2'b00
`define BMW_RESP_SLVERR   2'b10

`endif

// File: rtl/bmw_axil_slave.v
// AXI4-Lite slave front end that turns bus traffic into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "bmw_map.vh"

module bmw_axil_slave (
  input  wire                     clock,
  input  wire                     rst,
  input  wire [`BMW_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [`BMW_DATA_W-1:0]   s_axi_wdata,
  input  wire [`BMW_STRB_W-1:0]   s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`BMW_ADDR_W-1:0]   s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  output reg  [`BMW_DATA_W-1:0]   s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg                      wrEn,
  output reg  [`BMW_ADDR_W-1:0]   wrAddr,
  output reg  [`BMW_DATA_W-1:0]   wrData,
  output reg  [`BMW_STRB_W-1:0]   wrStrb,
  input  wire                     wrOk,
  input  wire [`BMW_DATA_W-1:0]   rdData,
  input  wire                     rdOk
);

  reg awHeld_reg;
  reg wHeld_reg;

  // Write path: address and data land in either order, then one strobe
  always @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BMW_RESP_OKAY;
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      wrEn          <= 1'b0;
      wrAddr        <= {`BMW_ADDR_W{1'b0}};
      wrData        <= {`BMW_DATA_W{1'b0}};
      wrStrb        <= {`BMW_STRB_W{1'b0}};
    end else begin
      wrEn          <= 1'b0;
      // Each ready only while its own channel holds nothing and no response is pending
      s_axi_awready <= !awHeld_reg && !s_axi_bvalid;
      s_axi_wready  <= !wHeld_reg && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg    <= 1'b1;
        wrAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg    <= 1'b1;
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        wrEn          <= 1'b1;
        awHeld_reg    <= 1'b0;
        wHeld_reg     <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrOk ? `BMW_RESP_OKAY : `BMW_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: data captured at the address handshake
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {`BMW_DATA_W{1'b0}};
      s_axi_rresp   <= `BMW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdData;
        s_axi_rresp   <= rdOk ? `BMW_RESP_OKAY : `BMW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b0;
      end
    end
  end

endmodule // bmw_axil_slave
`default_nettype wire

// File: rtl/bmw_window_cmp.v
// Inclusive 64-bit address window comparator
`timescale 1ns/1ps
`default_nettype none

module bmw_window_cmp (
  input  wire [63:0] addr,
  input  wire [63:0] floor,
  input  wire [63:0] ceiling,
  output wire        hit
);

  // Both ends inclusive; an inverted window never hits
  assign hit = (floor <= addr) && (addr <= ceiling);

endmodule // bmw_window_cmp
`default_nettype wire

// File: rtl/bmw_regs.v
// Memory and prefetchable window registers with forwarding decision
// Contract
// - Memory floor at bits 15:4 gives address 31:20; low 20 bits zero.
// - Memory ceiling at bits 31:20 gives address 31:20; low 20 bits ones.
// - Memory window bounds decide forwarding of memory transactions.
// - Prefetch floor at bits 15:4 gives address 31:20; low bits zero.
// - Prefetch ceiling at bits 31:20 gives address 31:20; low bits ones.
// - Prefetch floor upper half comes from its own 32-bit register.
// - Prefetch ceiling upper half comes from its own 32-bit register.
// - Floor upper register: writable 32 bits, address 63:32, resets zero.
// - Prefetch bounds decide forwarding of memory reads and writes.
// - Ceiling upper register: writable 32 bits, address 63:32, resets zero.
`timescale 1ns/1ps
`default_nettype none
`include "bmw_map.vh"

module bmw_regs (
  input  wire                     clock,
  input  wire                     rst,
  // Register bus
  input  wire [`BMW_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [`BMW_DATA_W-1:0]   s_axi_wdata,
  input  wire [`BMW_STRB_W-1:0]   s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  output wire [1:0]               s_axi_bresp,
  output wire                     s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`BMW_ADDR_W-1:0]   s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  output wire [`BMW_DATA_W-1:0]   s_axi_rdata,
  output wire [1:0]               s_axi_rresp,
  output wire                     s_axi_rvalid,
  input  wire                     s_axi_rready,
  // Transaction lookup from the forwarding logic
  input  wire                     txnValid,
  input  wire [63:0]              txnAddr,
  input  wire                     txnUpstream,
  // Lookup result, one cycle later
  output reg                      decValid,
  output reg                      memHit,
  output reg                      prefHit,
  output reg                      forward
);

  // Window registers
  reg  [11:0]              memFloor_reg;
  reg  [11:0]              memCeil_reg;
  reg  [11:0]              prefFloorLo_reg;
  reg  [11:0]              prefCeilLo_reg;
  reg  [31:0]              prefFloorHi_reg;
  reg  [31:0]              prefCeilHi_reg;
  // Observed lookup state
  reg  [15:0]              fwdCount_reg;
  reg  [15:0]              fwdCount_next;

  // Bus strobes
  wire                     wrEn;
  wire [`BMW_ADDR_W-1:0]   wrAddr;
  wire [`BMW_DATA_W-1:0]   wrData;
  wire [`BMW_STRB_W-1:0]   wrStrb;
  reg                      wrOk;
  reg  [`BMW_DATA_W-1:0]   rdData;
  reg                      rdOk;
  reg  [`BMW_DATA_W-1:0]   wrCur;
  wire [`BMW_DATA_W-1:0]   byteMask;
  wire [`BMW_DATA_W-1:0]   wrMerged;

  // Packed readback words
  wire [31:0]              memWord;
  wire [31:0]              prefWord;
  wire [31:0]              statusWord;

  // Full 64-bit bounds
  wire [63:0]              memFloorAddr;
  wire [63:0]              memCeilAddr;
  wire [63:0]              prefFloorAddr;
  wire [63:0]              prefCeilAddr;
  wire                     memInWin;
  wire                     prefInWin;
  wire                     anyInWin;
  wire                     fwdNow;

  bmw_axil_slave u_bus (
    .clock         (clock),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrOk          (wrOk),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // Readback images; low nibbles are constants, not storage
  assign memWord  = {memCeil_reg, `BMW_RESV_NIBBLE, memFloor_reg, `BMW_RESV_NIBBLE};
  assign prefWord = {prefCeilLo_reg, `BMW_ADDR64_IND, prefFloorLo_reg, `BMW_ADDR64_IND};
  assign statusWord = {fwdCount_reg, 13'h0000, forward, prefHit, memHit};

  // Byte lane mask from write strobes
  genvar lane;
  generate
    for (lane = 0; lane < `BMW_STRB_W; lane = lane + 1) begin : g_lane
      assign byteMask[8*lane +: 8] = {8{wrStrb[lane]}};
    end
  endgenerate

  // Current value under the write address, for partial-lane merges
  always @* begin
    wrCur = {`BMW_DATA_W{1'b0}};
    wrOk  = 1'b1;
    if (wrAddr == `BMW_OFS_MEM) begin
      wrCur = memWord;
    end else if (wrAddr == `BMW_OFS_PREF) begin
      wrCur = prefWord;
    end else if (wrAddr == `BMW_OFS_PFLOOR_HI) begin
      wrCur = prefFloorHi_reg;
    end else if (wrAddr == `BMW_OFS_PCEIL_HI) begin
      wrCur = prefCeilHi_reg;
    end else if (wrAddr == `BMW_OFS_STATUS) begin
      wrCur = statusWord;
    end else begin
      wrOk  = 1'b0;
    end
  end

  assign wrMerged = (wrCur & ~byteMask) | (wrData & byteMask);

  // Read decode; unmapped words read zero with an error response
  always @* begin
    rdData = {`BMW_DATA_W{1'b0}};
    rdOk   = 1'b1;
    if (s_axi_araddr == `BMW_OFS_MEM) begin
      rdData = memWord;
    end else if (s_axi_araddr == `BMW_OFS_PREF) begin
      rdData = prefWord;
    end else if (s_axi_araddr == `BMW_OFS_PFLOOR_HI) begin
      rdData = prefFloorHi_reg;
    end else if (s_axi_araddr == `BMW_OFS_PCEIL_HI) begin
      rdData = prefCeilHi_reg;
    end else if (s_axi_araddr == `BMW_OFS_STATUS) begin
      rdData = statusWord;
    end else begin
      rdOk   = 1'b0;
    end
  end

  // Window field storage; only the address fields take write data
  always @(posedge clock) begin
    if (rst) begin
      memFloor_reg    <= `BMW_WIN_RST;
      memCeil_reg     <= `BMW_WIN_RST;
      prefFloorLo_reg <= `BMW_WIN_RST;
      prefCeilLo_reg  <= `BMW_WIN_RST;
      prefFloorHi_reg <= `BMW_HI_RST;
      prefCeilHi_reg  <= `BMW_HI_RST;
    end else if (wrEn) begin
      if (wrAddr == `BMW_OFS_MEM) begin
        memFloor_reg <= wrMerged[`BMW_FLOOR_MSB:`BMW_FLOOR_LSB];
        memCeil_reg  <= wrMerged[`BMW_CEIL_MSB:`BMW_CEIL_LSB];
      end else if (wrAddr == `BMW_OFS_PREF) begin
        prefFloorLo_reg <= wrMerged[`BMW_FLOOR_MSB:`BMW_FLOOR_LSB];
        prefCeilLo_reg  <= wrMerged[`BMW_CEIL_MSB:`BMW_CEIL_LSB];
      end else if (wrAddr == `BMW_OFS_PFLOOR_HI) begin
        prefFloorHi_reg <= wrMerged;
      end else if (wrAddr == `BMW_OFS_PCEIL_HI) begin
        prefCeilHi_reg  <= wrMerged;
      end
    end
  end

  // Bounds; the memory window lives below 4 GB only
  assign memFloorAddr  = {32'h00000000, memFloor_reg, `BMW_LOW_FILL};
  assign memCeilAddr   = {32'h00000000, memCeil_reg, `BMW_HIGH_FILL};
  assign prefFloorAddr = {prefFloorHi_reg, prefFloorLo_reg, `BMW_LOW_FILL};
  assign prefCeilAddr  = {prefCeilHi_reg, prefCeilLo_reg, `BMW_HIGH_FILL};

  // Two comparators so both windows resolve in the same cycle
  bmw_window_cmp u_memCmp (
    .addr    (txnAddr),
    .floor   (memFloorAddr),
    .ceiling (memCeilAddr),
    .hit     (memInWin)
  );

  bmw_window_cmp u_prefCmp (
    .addr    (txnAddr),
    .floor   (prefFloorAddr),
    .ceiling (prefCeilAddr),
    .hit     (prefInWin)
  );

  // Downstream passes inside a window, upstream passes outside all of them
  assign anyInWin = memInWin || prefInWin;
  assign fwdNow   = txnUpstream ? !anyInWin : anyInWin;

  // Lookup result register; held between lookups for status reads
  always @(posedge clock) begin
    if (rst) begin
      decValid <= 1'b0;
      memHit   <= 1'b0;
      prefHit  <= 1'b0;
      forward  <= 1'b0;
    end else begin
      decValid <= txnValid;
      if (txnValid) begin
        memHit  <= memInWin;
        prefHit <= prefInWin;
        forward <= fwdNow;
      end
    end
  end

  // Forward counter: a write to status clears it, but a same-cycle forward still counts
  always @* begin
    fwdCount_next = fwdCount_reg;
    if (wrEn && wrAddr == `BMW_OFS_STATUS) begin
      fwdCount_next = `BMW_CNT_RST;
    end
    if (txnValid && fwdNow && fwdCount_next != `BMW_CNT_MAX) begin
      fwdCount_next = fwdCount_next + 16'h0001;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      fwdCount_reg <= `BMW_CNT_RST;
    end else begin
      fwdCount_reg <= fwdCount_next;
    end
  end

endmodule // bmw_regs
`default_nettype wire

// File: testbench/bmw_fwd_model.sv
// Forwarding-logic model that issues window lookups
`timescale 1ns/1ps
`default_nettype none

module bmw_fwd_model (
  input  wire logic        clock,
  output var  logic        txnValid,
  output var  logic [63:0] txnAddr,
  output var  logic        txnUpstream
);
  initial begin
    txnValid = 1'b0;
    txnAddr = 64'h0;
    txnUpstream = 1'b0;
  end

  // One-cycle request; inputs scrambled afterwards so stale values never match
  task automatic lookup(input logic [63:0] a, input logic up);
    @(posedge clock);
    txnValid <= 1'b1;
    txnAddr <= a;
    txnUpstream <= up;
    @(posedge clock);
    txnValid <= 1'b0;
    txnAddr <= ~a;
    txnUpstream <= ~up;
  endtask
endmodule // bmw_fwd_model

`default_nettype wire

// File: testbench/bmw_regs_props.sv
// Assertions on the window register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "bmw_map.vh"

module bmw_regs_props (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic [`BMW_DATA_W-1:0] s_axi_rdata,
  input wire logic                   txnValid,
  input wire logic [63:0]            txnAddr,
  input wire logic                   txnUpstream,
  input wire logic                   decValid,
  input wire logic                   memHit,
  input wire logic                   prefHit,
  input wire logic                   forward
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Lookup answers come exactly one cycle after the request
  a_dec_follows: assert property (txnValid |=> decValid)
    else $error("lookup not answered next cycle");
  a_dec_cause: assert property (decValid |-> $past(txnValid))
    else $error("answer without lookup");
  a_fwd_down: assert property (decValid && !$past(txnUpstream) |-> forward == (memHit || prefHit))
    else $error("downstream forward wrong");
  a_fwd_up: assert property (decValid && $past(txnUpstream) |-> forward != (memHit || prefHit))
    else $error("upstream forward wrong");
  a_result_hold: assert property (!decValid |-> $stable({memHit, prefHit, forward}))
    else $error("result changed without lookup");
  // Memory window never covers addresses above 4 GB
  a_mem_low32: assert property (decValid && ($past(txnAddr) >> 32) != 64'h0 |-> !memHit)
    else $error("memory window hit above 4 GB");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `BMW_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
endmodule // bmw_regs_props

bind bmw_regs bmw_regs_props i_props (
  .clock(clock), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .txnValid(txnValid), .txnAddr(txnAddr), .txnUpstream(txnUpstream),
  .decValid(decValid), .memHit(memHit), .prefHit(prefHit), .forward(forward)
);

`default_nettype wire

// File: testbench/test_bridge_memory_window_regs.sv
// Register and lookup tests of the memory window bank
`timescale 1ns/1ps
`default_nettype none
`include "bmw_map.vh"

module test_bridge_memory_window_regs;
  logic        clock, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        txnValid, txnUpstream, decValid, memHit, prefHit, forward;
  logic [63:0] txnAddr;
  int          num_errors = 0, comparisons = 0, cycles = 0;

  bmw_regs i_dut (
    .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .txnValid(txnValid), .txnAddr(txnAddr), .txnUpstream(txnUpstream), .decValid(decValid),
    .memHit(memHit), .prefHit(prefHit), .forward(forward)
  );
  bmw_fwd_model i_fwd (.clock(clock), .txnValid(txnValid), .txnAddr(txnAddr), .txnUpstream(txnUpstream));

  always #5 clock = ~clock;

  // Watchdog; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address and data offered together; response accepted late to exercise the hold
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check("rdata", exp, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  // Forward is expected exactly when a window claims a downstream lookup, or when no window claims an upstream one
  task automatic look(input logic [63:0] a, input logic up, input logic em, input logic ep);
    i_fwd.lookup(a, up);
    #1;
    check("decValid", 1, decValid);
    check("memHit", em, memHit);
    check("prefHit", ep, prefHit);
    check("forward", up ? !(em | ep) : (em | ep), forward);
  endtask

  initial begin
    clock = 0; rst = 1;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 0;
    s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    repeat (20) @(posedge clock);
    rst <= 0;
    rd(12'h020, 32'h0, 2'b00);
    rd(12'h024, 32'h00010001, 2'b00);
    rd(12'h028, 32'h0, 2'b00);
    rd(12'h02c, 32'h0, 2'b00);
    wr(12'h020, 32'hffffffff, 4'hf, 2'b00); rd(12'h020, 32'hfff0fff0, 2'b00);
    wr(12'h024, 32'hffffffff, 4'hf, 2'b00); rd(12'h024, 32'hfff1fff1, 2'b00);
    wr(12'h028, 32'h12345678, 4'hf, 2'b00); wr(12'h028, 32'h000000aa, 4'h1, 2'b00);
    rd(12'h028, 32'h123456aa, 2'b00);
    wr(12'h02c, 32'hffffffff, 4'hf, 2'b00); rd(12'h02c, 32'hffffffff, 2'b00);
    wr(12'h030, 32'h5a5a5a5a, 4'hf, `BMW_RESP_SLVERR); rd(12'h030, 32'h0, `BMW_RESP_SLVERR);
    // Memory window 0x10000000..0x1fffffff, prefetch 0x1_20000000..0x2_300fffff
    wr(12'h020, 32'h1ff01000, 4'hf, 2'b00);
    wr(12'h024, 32'h30002000, 4'hf, 2'b00);
    wr(12'h028, 32'h1, 4'hf, 2'b00);
    wr(12'h02c, 32'h2, 4'hf, 2'b00);
    look(64'h10000000, 0, 1, 0);
    look(64'h0fffffff, 0, 0, 0);
    look(64'h1fffffff, 1, 1, 0);
    look(64'h20000000, 1, 0, 0);
    look(64'h1_10000000, 0, 0, 0);
    look(64'h1_20000000, 0, 0, 1);
    look(64'h1_1fffffff, 1, 0, 0);
    look(64'h2_300fffff, 1, 0, 1);
    look(64'h2_30100000, 0, 0, 0);
    look(64'h0_20000000, 0, 0, 0);
    // Four of the lookups above forwarded; the last one hit nothing
    rd(12'h100, 32'h00040000, 2'b00);
    wr(12'h100, 32'h0, 4'hf, 2'b00);
    rd(12'h100, 32'h0, 2'b00);
    // Mid-run reset must drop the held result and the programmed windows
    look(64'h10000000, 0, 1, 0);
    @(posedge clock);
    rst <= 1;
    repeat (3) @(posedge clock);
    check("memHit in reset", 0, memHit);
    check("forward in reset", 0, forward);
    rst <= 0;
    rd(12'h020, 32'h0, 2'b00);
    rd(12'h028, 32'h0, 2'b00);
    look(64'h0, 0, 1, 1);
    look(64'h100000, 0, 0, 0);
    finish_test();
  end
endmodule // test_bridge_memory_window_regs

`default_nettype wire
